// ---- rtl/cric_i2c_target.sv ----
// Two-wire bus target with register pointer and auto-increment.
module cric_i2c_target
  import cric_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_n_out,
  output cric_req_t       req_out,
  input  wire logic [7:0] rdata_in
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_RX   = 5'b01000,
    ST_TX   = 5'b10000
  } cric_st_t;

  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       scl_prev_ff, sda_prev_ff;
  cric_st_t   st_ff, nxt_st;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bit_ff, nxt_bit;
  logic       rnw_ff, nxt_rnw;
  logic       havptr_ff, nxt_havptr;
  logic [7:0] ptr_ff, nxt_ptr;
  logic       oe_n_ff, nxt_oe_n;
  cric_req_t  req_ff, nxt_req;
  logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

  assign scl_s    = scl_sync_ff[1];
  assign sda_s    = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start_c  = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_c   = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign sda_oe_n_out = oe_n_ff;
  assign req_out  = req_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_shift = shift_ff;
    nxt_bit = bit_ff;
    nxt_rnw = rnw_ff;
    nxt_havptr = havptr_ff;
    nxt_ptr = ptr_ff;
    nxt_oe_n = oe_n_ff;
    nxt_req = '0;
    if (start_c) begin
      nxt_st = ST_ADDR;
      nxt_bit = 4'h0;
      nxt_oe_n = 1'b1;
      nxt_havptr = 1'b0;
    end else if (stop_c) begin
      nxt_st = ST_IDLE;
      nxt_oe_n = 1'b1;
    end else begin
      case (st_ff)
        ST_IDLE: nxt_oe_n = 1'b1;
        ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            if (shift_ff[7:1] == CRIC_DEV_ADDR) begin // R12
              nxt_rnw = shift_ff[0];
              nxt_oe_n = 1'b0;
              nxt_st = ST_ACK;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rnw_ff) begin
              nxt_shift = rdata_in;
              nxt_oe_n = rdata_in[7];
              nxt_st = ST_TX;
              nxt_ptr = ptr_ff + 8'h01; // R14
            end else begin
              nxt_oe_n = 1'b1;
              nxt_st = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            nxt_oe_n = 1'b0;
            nxt_st = ST_ACK;
            if (!havptr_ff) begin
              nxt_ptr = shift_ff;
              nxt_havptr = 1'b1;
            end else begin
              nxt_req.wr = 1'b1;
              nxt_req.addr = ptr_ff;
              nxt_req.wdata = shift_ff;
              nxt_ptr = ptr_ff + 8'h01; // R14
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h8 && sda_s) begin
              nxt_st = ST_IDLE;
            end
          end
          if (scl_fall) begin
            if (bit_ff == 4'h9) begin
              nxt_bit = 4'h0;
              nxt_shift = rdata_in;
              nxt_oe_n = rdata_in[7];
              nxt_ptr = ptr_ff + 8'h01; // R14
            end else if (bit_ff == 4'h8) begin
              nxt_oe_n = 1'b1;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe_n = shift_ff[6];
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
    nxt_req.addr = (nxt_req.wr) ? nxt_req.addr : nxt_ptr;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      st_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      rnw_ff <= 1'b0;
      havptr_ff <= 1'b0;
      ptr_ff <= 8'h00;
      oe_n_ff <= 1'b1;
      req_ff <= '0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      st_ff <= nxt_st;
      shift_ff <= nxt_shift;
      bit_ff <= nxt_bit;
      rnw_ff <= nxt_rnw;
      havptr_ff <= nxt_havptr;
      ptr_ff <= nxt_ptr;
      oe_n_ff <= nxt_oe_n;
      req_ff <= nxt_req;
    end
  end

endmodule

// ---- rtl/cric_pkg.sv ----
// Package with register map, timing counts and carrier types of the reset and init controller.
package cric_pkg;

  localparam logic [6:0] CRIC_DEV_ADDR         = 7'h18;
  localparam logic [7:0] CRIC_REG_PAGE_SEL     = 8'h00;
  localparam logic [7:0] CRIC_REG_SW_RESET     = 8'h01;
  localparam logic [7:0] CRIC_REG_PWR_CTRL     = 8'h02;
  localparam logic [7:0] CRIC_REG_STATUS       = 8'h03;
  localparam logic [7:0] CRIC_REG_HP_STAGE_RST = 8'h1F;
  localparam logic [7:0] CRIC_REG_SPK_STAGE_RST = 8'h20;
  localparam logic [7:0] CRIC_REG_OC_STATUS    = 8'h21;
  localparam logic [7:0] CRIC_PAGE0            = 8'h00;
  localparam logic [7:0] CRIC_PAGE1            = 8'h01;
  localparam int         CRIC_SW_RESET_BIT     = 0;
  localparam int         CRIC_HPL_RST_BIT      = 7;
  localparam int         CRIC_HPR_RST_BIT      = 6;
  localparam int         CRIC_SPK_RST_BIT      = 7;
  localparam int         CRIC_PLL_PWR_BIT      = 0;
  localparam logic [7:0] CRIC_REG_RESET_VAL    = 8'h00;
  localparam int         CRIC_NUM_REGS         = 64;

  localparam int CRIC_CLK_MHZ        = 100;
  localparam int CRIC_INIT_TIME_US   = 1000;
  localparam int CRIC_PLL_TIME_US    = 10000;
  localparam int CRIC_INIT_CYCLES    = CRIC_INIT_TIME_US * CRIC_CLK_MHZ;
  localparam int CRIC_PLL_CYCLES     = CRIC_PLL_TIME_US * CRIC_CLK_MHZ;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cric_req_t;

  typedef struct packed {
    logic left_headphone_out;
    logic right_headphone_out;
    logic spk;
  } cric_stage_t;

endpackage

// ---- rtl/cric_top.sv ----
// Reset, start-up lockout, clock gating and power-stage recovery controller of the codec.
// Functional notes
// R1 - Reset held low 10 ns restores defaults.
// R2 - Page 0 register 1 D0 software reset.
// R3 - Memory initialisation completes within 1 ms.
// R4 - Host avoids coefficient buffers during initialisation.
// R5 - Host powers nothing up during initialisation.
// R6 - PLL clocks released 10 ms after power-up.
// R7 - Stage reset re-enables output, keeps registers.
// R8 - Page 1 reg 31 D7/D6 reset headphones.
// R9 - Page 1 reg 32 D7 resets speaker.
// R10 - All blocks start powered down.
// R11 - Power down keeps every register value.
// R12 - Target only at address 001 1000.
// R13 - Registers 8-bit with full read-back.
// R14 - Auto-increment and fast-mode support.
// R15 - Keep reset low during core ramp.
// R16 - Page select register chooses register page.
module cric_top
  import cric_pkg::*;
#(
  parameter int INIT_CYCLES = CRIC_INIT_CYCLES,
  parameter int PLL_CYCLES  = CRIC_PLL_CYCLES
)(
  // Clock and reset.
  input  wire logic       REF_CLK_IN,
  input  wire logic       RESET_N_IN,
  // Control bus pins.
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OE_N_OUT,
  // Overcurrent shutdown events from the output stages.
  input  wire logic       HPL_OC_IN,
  input  wire logic       HPR_OC_IN,
  input  wire logic       SPK_OC_IN,
  // Status and enables.
  output logic            INIT_BUSY_OUT,
  output logic            CODEC_CLK_EN_OUT,
  output logic [7:0]      BLOCK_PWR_OUT,
  output logic            LEFT_HEADPHONE_OUT_EN_OUT,
  output logic            RIGHT_HEADPHONE_OUT_EN_OUT,
  output logic            SPEAKER_OUT_EN_OUT
);

  cric_req_t   req;
  logic [7:0]  rdata;
  logic        sw_rst_ff, nxt_sw_rst;
  logic [7:0]  page_ff, nxt_page;
  localparam int NUM_SLOTS = 2 * CRIC_NUM_REGS;
  logic [7:0]  regs_ff [NUM_SLOTS];
  logic [7:0]  nxt_regs [NUM_SLOTS];
  logic [31:0] init_cnt_ff, nxt_init_cnt;
  logic [31:0] pll_cnt_ff, nxt_pll_cnt;
  logic        clk_en_ff, nxt_clk_en;
  logic [2:0]  oc_sync1_ff, oc_sync2_ff;
  cric_stage_t trip_ff, nxt_trip;
  cric_stage_t stage_rst;
  logic        init_busy;
  logic        pll_on;

  cric_i2c_target u_target (
    .clk_in       (REF_CLK_IN),
    .rst_n_in     (RESET_N_IN),
    .scl_in       (SCL_IN),
    .sda_in       (SDA_IN),
    .sda_oe_n_out (SDA_OE_N_OUT),
    .req_out      (req),
    .rdata_in     (rdata)
  );

  assign init_busy = (init_cnt_ff != 32'h0);
  assign pll_on    = regs_ff[{1'b0, CRIC_REG_PWR_CTRL[5:0]}][CRIC_PLL_PWR_BIT];

  // Page bit 0 picks one of two banks of 64 slots, so no register aliases another one on its page.
  function automatic logic [6:0] slot(input logic [7:0] pg, input logic [7:0] a);
    slot = {pg[0], a[5:0]};
  endfunction

  always_comb begin
    rdata = 8'h00;
    if (req.addr == CRIC_REG_PAGE_SEL) begin
      rdata = page_ff; // R16
    end else if (page_ff == CRIC_PAGE0 && req.addr == CRIC_REG_STATUS) begin
      rdata = {6'h00, clk_en_ff, init_busy};
    end else if (page_ff == CRIC_PAGE1 && req.addr == CRIC_REG_OC_STATUS) begin
      rdata = {trip_ff.left_headphone_out, trip_ff.right_headphone_out, trip_ff.spk, 5'h00};
    end else if (req.addr[7:6] == 2'b00) begin
      rdata = regs_ff[slot(page_ff, req.addr)]; // R13
    end
  end

  always_comb begin
    nxt_sw_rst = 1'b0;
    nxt_page = page_ff;
    stage_rst = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (req.wr) begin
      if (req.addr == CRIC_REG_PAGE_SEL) begin
        nxt_page = req.wdata; // R16
      end else if (page_ff == CRIC_PAGE0 && req.addr == CRIC_REG_SW_RESET) begin
        nxt_sw_rst = req.wdata[CRIC_SW_RESET_BIT]; // R2
      end else if (page_ff == CRIC_PAGE1 && req.addr == CRIC_REG_HP_STAGE_RST) begin
        stage_rst.left_headphone_out = req.wdata[CRIC_HPL_RST_BIT]; // R8
        stage_rst.right_headphone_out = req.wdata[CRIC_HPR_RST_BIT]; // R8
        nxt_regs[slot(page_ff, req.addr)] = req.wdata & 8'h3F;
      end else if (page_ff == CRIC_PAGE1 && req.addr == CRIC_REG_SPK_STAGE_RST) begin
        stage_rst.spk = req.wdata[CRIC_SPK_RST_BIT]; // R9
        nxt_regs[slot(page_ff, req.addr)] = req.wdata & 8'h7F;
      end else if (page_ff == CRIC_PAGE0 && req.addr == CRIC_REG_PWR_CTRL && init_busy) begin
        nxt_regs[slot(page_ff, req.addr)] = regs_ff[slot(page_ff, req.addr)];
      end else if (req.addr[7:6] == 2'b00) begin
        nxt_regs[slot(page_ff, req.addr)] = req.wdata; // R13
      end
    end
  end

  // Stage reset clears the trip latch only; set by a new overcurrent wins.
  always_comb begin
    nxt_trip.left_headphone_out = oc_sync2_ff[2] | (trip_ff.left_headphone_out & ~stage_rst.left_headphone_out); // R7
    nxt_trip.right_headphone_out = oc_sync2_ff[1] | (trip_ff.right_headphone_out & ~stage_rst.right_headphone_out); // R7
    nxt_trip.spk = oc_sync2_ff[0] | (trip_ff.spk & ~stage_rst.spk); // R7
  end

  always_comb begin
    nxt_init_cnt = (init_cnt_ff != 32'h0) ? init_cnt_ff - 32'h1 : 32'h0; // R3
    nxt_pll_cnt = pll_cnt_ff;
    nxt_clk_en = clk_en_ff;
    if (!pll_on) begin
      nxt_pll_cnt = 32'(PLL_CYCLES); // R6
      nxt_clk_en = 1'b0;
    end else if (pll_cnt_ff > 32'h1) begin
      nxt_pll_cnt = pll_cnt_ff - 32'h1; // R6
    end else begin
      nxt_clk_en = 1'b1; // R6
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      oc_sync1_ff <= 3'h0;
      oc_sync2_ff <= 3'h0;
    end else begin
      oc_sync1_ff <= {HPL_OC_IN, HPR_OC_IN, SPK_OC_IN};
      oc_sync2_ff <= oc_sync1_ff;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin // R1
      sw_rst_ff <= 1'b0;
      page_ff <= CRIC_PAGE0;
      init_cnt_ff <= 32'(INIT_CYCLES);
      pll_cnt_ff <= 32'(PLL_CYCLES);
      clk_en_ff <= 1'b0;
      trip_ff <= '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs_ff[i] <= CRIC_REG_RESET_VAL; // R10
      end
    end else if (sw_rst_ff) begin // R2
      sw_rst_ff <= 1'b0;
      page_ff <= CRIC_PAGE0;
      init_cnt_ff <= 32'(INIT_CYCLES); // R3
      pll_cnt_ff <= 32'(PLL_CYCLES);
      clk_en_ff <= 1'b0;
      trip_ff <= '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs_ff[i] <= CRIC_REG_RESET_VAL; // R10
      end
    end else begin
      sw_rst_ff <= nxt_sw_rst;
      page_ff <= nxt_page;
      init_cnt_ff <= nxt_init_cnt;
      pll_cnt_ff <= nxt_pll_cnt;
      clk_en_ff <= nxt_clk_en;
      trip_ff <= nxt_trip;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs_ff[i] <= nxt_regs[i]; // R11
      end
    end
  end

  assign INIT_BUSY_OUT              = init_busy;
  assign CODEC_CLK_EN_OUT           = clk_en_ff;
  assign BLOCK_PWR_OUT              = regs_ff[{1'b0, CRIC_REG_PWR_CTRL[5:0]}]; // R10
  assign LEFT_HEADPHONE_OUT_EN_OUT  = ~trip_ff.left_headphone_out; // R7
  assign RIGHT_HEADPHONE_OUT_EN_OUT = ~trip_ff.right_headphone_out; // R7
  assign SPEAKER_OUT_EN_OUT         = ~trip_ff.spk; // R7

endmodule

// ---- test/cric_top_assertions.sv ----
// Checker of reset, lockout, clock release and stage recovery at the controller ports.
module cric_top_assertions
  import cric_pkg::*;
#(
  parameter int INIT_CYCLES = CRIC_INIT_CYCLES,
  parameter int PLL_CYCLES  = CRIC_PLL_CYCLES
)(
  // Watched ports.
  input wire logic       REF_CLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic       SCL_IN,
  input wire logic       SDA_OE_N_OUT,
  input wire logic       HPL_OC_IN,
  input wire logic       INIT_BUSY_OUT,
  input wire logic       CODEC_CLK_EN_OUT,
  input wire logic [7:0] BLOCK_PWR_OUT,
  input wire logic       LEFT_HEADPHONE_OUT_EN_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy_cnt_ff;
  int nxt_busy_cnt;
  int pll_cnt_ff;
  int nxt_pll_cnt;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  always_comb begin
    nxt_busy_cnt = INIT_BUSY_OUT ? busy_cnt_ff + 1 : 0;
    nxt_pll_cnt  = BLOCK_PWR_OUT[CRIC_PLL_PWR_BIT] ? pll_cnt_ff + 1 : 0;
  end
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      busy_cnt_ff <= 0;
      pll_cnt_ff  <= 0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
      pll_cnt_ff  <= nxt_pll_cnt;
    end
  end
  rst_state_a: assert property ($rose(RESET_N_IN) |-> BLOCK_PWR_OUT == 8'h00 && !CODEC_CLK_EN_OUT && INIT_BUSY_OUT)
    else $error("reset state wrong");
  init_len_a: assert property ($fell(INIT_BUSY_OUT) |-> $past(busy_cnt_ff) inside {[INIT_CYCLES-3:INIT_CYCLES+3]})
    else $error("init length wrong");
  init_lock_a: assert property (INIT_BUSY_OUT && $past(INIT_BUSY_OUT) |-> BLOCK_PWR_OUT == 8'h00)
    else $error("power set during init");
  pll_wait_a: assert property ($rose(CODEC_CLK_EN_OUT) |-> pll_cnt_ff inside {[PLL_CYCLES-2:PLL_CYCLES+3]})
    else $error("clock release early");
  pll_due_a: assert property (BLOCK_PWR_OUT[0] && pll_cnt_ff > PLL_CYCLES + 3 |-> CODEC_CLK_EN_OUT)
    else $error("clock release late");
  oc_off_a: assert property (HPL_OC_IN |-> ##[1:5] !LEFT_HEADPHONE_OUT_EN_OUT)
    else $error("stage not shut down");
  stage_wr_a: assert property ($rose(LEFT_HEADPHONE_OUT_EN_OUT) |-> !SCL_IN)
    else $error("stage enabled without write");
  sda_move_a: assert property ($changed(SDA_OE_N_OUT) |-> !SCL_IN)
    else $error("data moved with clock high");
endmodule
bind cric_top cric_top_assertions #(.INIT_CYCLES(INIT_CYCLES), .PLL_CYCLES(PLL_CYCLES)) i_chk (
  .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .SCL_IN(SCL_IN), .SDA_OE_N_OUT(SDA_OE_N_OUT),
  .HPL_OC_IN(HPL_OC_IN), .INIT_BUSY_OUT(INIT_BUSY_OUT), .CODEC_CLK_EN_OUT(CODEC_CLK_EN_OUT),
  .BLOCK_PWR_OUT(BLOCK_PWR_OUT), .LEFT_HEADPHONE_OUT_EN_OUT(LEFT_HEADPHONE_OUT_EN_OUT));

// ---- test/cric_host_model.sv ----
// Two-wire bus controller model standing in for the host processor.
module cric_host_model
  import cric_pkg::*;
(
  // Bus pins.
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves only while the clock is low, each phase at least 8 cycles.
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wt(8);
    scl_out <= 1'b1;
    wt(4);
    r = sda_in;
    wt(4);
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic start;
    wt(1);
    sda_out <= 1'b1;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_out <= 1'b0;
    wt(8);
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic stop;
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_out <= 1'b1;
    wt(8);
  endtask
  task automatic put(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic probe(input logic [6:0] a, output logic nak);
    start();
    put({a, 1'b0}, nak);
    stop();
  endtask
  // The model never touches coefficient buffers.
  task automatic wr2(input logic [7:0] p, input logic [15:0] d, output logic nak);
    logic n1, n2, n3, n4;
    start();
    put({CRIC_DEV_ADDR, 1'b0}, n1);
    put(p, n2);
    put(d[15:8], n3);
    put(d[7:0], n4);
    stop();
    nak = n1 | n2 | n3 | n4;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic n1, n2, n3;
    start();
    put({CRIC_DEV_ADDR, 1'b0}, n1);
    put(p, n2);
    put(d, n3);
    stop();
    nak = n1 | n2 | n3;
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic nak);
    logic n1, n2, n3;
    start();
    put({CRIC_DEV_ADDR, 1'b0}, n1);
    put(p, n2);
    start();
    put({CRIC_DEV_ADDR, 1'b1}, n3);
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
    nak = n1 | n2 | n3;
  endtask
endmodule

// ---- test/codec_reset_init_control_test.sv ----
// Self-checking bench of the reset and init controller driven by the host model.
`define CHK(nm, e, g) begin \
  #1; \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module codec_reset_init_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cric_pkg::*;
  localparam int INIT_N = 1000;
  localparam int PLL_N  = 1500;
  logic        ref_clk, reset_n, scl, host_sda, sda_line, sda_oe_n, busy, clk_en, nak;
  logic [2:0]  oc, stage;
  logic [7:0]  pwr;
  logic [15:0] rv;
  int          num_errors, n_tests, n;
  assign sda_line = host_sda & sda_oe_n;
  cric_top #(.INIT_CYCLES(INIT_N), .PLL_CYCLES(PLL_N)) i_dut (
    .REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OE_N_OUT(sda_oe_n),
    .HPL_OC_IN(oc[2]), .HPR_OC_IN(oc[1]), .SPK_OC_IN(oc[0]), .INIT_BUSY_OUT(busy), .CODEC_CLK_EN_OUT(clk_en),
    .BLOCK_PWR_OUT(pwr), .LEFT_HEADPHONE_OUT_EN_OUT(stage[2]), .RIGHT_HEADPHONE_OUT_EN_OUT(stage[1]),
    .SPEAKER_OUT_EN_OUT(stage[0]));
  cric_host_model i_host (.clk_in(ref_clk), .sda_in(sda_line), .scl_out(scl), .sda_out(host_sda));
  task t_reset;
    `CHK("reset", 13'h1007, {busy, pwr, clk_en, stage})
    n = 0;
    while (busy === 1'b1 && n < 2 * INIT_N) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("init_len", 1'b1, n > INIT_N - 4 && n <= INIT_N + 3)
  endtask
  task t_regs;
    i_host.probe(7'h19, nak);
    `CHK("bad_addr", 1'b1, nak)
    i_host.wr2(8'h10, 16'hA55A, nak);
    `CHK("wr_ack", 1'b0, nak)
    i_host.rd(8'h10, rv, nak);
    `CHK("autoinc", 16'hA55A, rv)
    i_host.wr2(8'h3F, 16'h5AC3, nak);
    i_host.rd(8'h3F, rv, nak);
    `CHK("map_end", 16'h5A00, rv)
    i_host.wr(8'h25, 8'h11, nak);
    i_host.wr(CRIC_REG_PAGE_SEL, CRIC_PAGE1, nak);
    i_host.wr(8'h25, 8'h22, nak);
    i_host.rd(8'h24, rv, nak);
    `CHK("page1", 16'h0022, rv)
    i_host.wr(CRIC_REG_PAGE_SEL, CRIC_PAGE0, nak);
    i_host.rd(8'h24, rv, nak);
    `CHK("page0", 16'h0011, rv)
  endtask
  task t_pll;
    i_host.wr(CRIC_REG_PWR_CTRL, 8'h01, nak);
    `CHK("pwr", 8'h01, pwr)
    repeat (PLL_N - 60) @(posedge ref_clk);
    `CHK("clk_early", 1'b0, clk_en)
    repeat (80) @(posedge ref_clk);
    `CHK("clk_on", 1'b1, clk_en)
  endtask
  task t_stage;
    @(posedge ref_clk);
    oc <= 3'b111;
    @(posedge ref_clk);
    oc <= 3'b000;
    repeat (6) @(posedge ref_clk);
    `CHK("tripped", 3'b000, stage)
    i_host.wr(CRIC_REG_PAGE_SEL, CRIC_PAGE1, nak);
    i_host.rd(CRIC_REG_OC_STATUS, rv, nak);
    `CHK("trips", 8'hE0, rv[15:8])
    i_host.wr(CRIC_REG_HP_STAGE_RST, 8'h80, nak);
    `CHK("left", 3'b100, stage)
    i_host.wr(CRIC_REG_HP_STAGE_RST, 8'h40, nak);
    `CHK("right", 3'b110, stage)
    i_host.wr(CRIC_REG_SPK_STAGE_RST, 8'h80, nak);
    `CHK("speaker", 3'b111, stage)
    `CHK("kept", 9'h003, {pwr, clk_en})
  endtask
  task t_swrst;
    i_host.wr(CRIC_REG_PAGE_SEL, CRIC_PAGE0, nak);
    i_host.wr(CRIC_REG_SW_RESET, 8'h01, nak);
    `CHK("sw_state", 10'h200, {busy, pwr, clk_en})
    i_host.wr(CRIC_REG_PWR_CTRL, 8'h01, nak);
    `CHK("locked", 8'h00, pwr)
    i_host.rd(8'h10, rv, nak);
    `CHK("sw_regs", 16'h0000, rv)
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
  initial begin
    num_errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    oc = 3'b000;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_pll();
    t_stage();
    t_swrst();
    conclude();
  end
endmodule
